/* File: contact_model.sv */
// Bouncing switch contact feeding the timer input.
// Assumes the bench changes cmd_in just after a rising edge.
`timescale 1ns/1ps
module contact_model (
    input wire clk_in,
    input wire cmd_in,
    input wire [3:0] bounce_in,
    output reg contact_out
);
    reg [3:0] left_ff = 4'h0;
    reg last_ff = 1'b0;
    initial contact_out = 1'b0;
    // Chatter toggles every cycle; each change of cmd_in restarts the pending count
    always @(posedge clk_in) begin
        if (cmd_in != last_ff) begin
            last_ff <= cmd_in;
            left_ff <= bounce_in;
        end else if (left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
        contact_out <= (left_ff != 4'h0) ? ~contact_out : last_ff;
    end
endmodule // contact_model

/* File: delay_timer_defs.vh */
// Constants for the on/off delay timer block.
// Included by delay_timer_io_filter.v; definitions only.
`ifndef DELAY_TIMER_DEFS_VH
`define DELAY_TIMER_DEFS_VH

// Register byte offsets
`define REG_CTRL_ADDR 8'h00
`define REG_ON_DELAY_ADDR 8'h04
`define REG_OFF_DELAY_ADDR 8'h08
`define REG_STATUS_ADDR 8'h0C

// Control register fields
`define CTRL_IN_FUNC_LSB 0
`define CTRL_OUT_FUNC_LSB 8
`define CTRL_RUN_BIT 16

// Function codes that enable the timer
`define FUNC_TIMER_IN 8'h12
`define FUNC_TIMER_OUT 8'h0C

// Status fields
`define STAT_OUT_BIT 0
`define STAT_IN_BIT 1
`define STAT_EN_BIT 2
`define STAT_REJ_BIT 3

// Delay settings in 0.1 s units
`define DELAY_MAX 12'hBB8
`define DELAY_RESET 12'h000

// Tick timing
`define TICK_MS 100
`define CLK_KHZ 50000

`endif

/* File: delay_timer_io_filter.v */
// On-delay / off-delay timer between a digital input and a digital output.
// Assumes one 50 MHz clock, a classic Wishbone master, synchronous input.
// Function
// - Timer active only when input function is 18 and output function is 12.
// - Output turns on after input stays on longer than the on-delay.
// - Output turns off after input stays off longer than the off-delay.
// - Delay settings are write-protected while the drive runs.
// - Input and output are general purpose, filtering sensor or switch bounce.
`timescale 1ns/1ps
`include "delay_timer_defs.vh"

module delay_timer_io_filter #(
    parameter TICK_CYCLES = (`TICK_MS * `CLK_KHZ),
    parameter DW = 12
) (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire drive_running_in,
    input wire timer_in,
    output reg timer_out
);

    // Release is delayed two edges so every flop leaves reset together
    reg rst_meta_ff;
    reg rst_sync_ff;
    wire rst_n = rst_sync_ff;

    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    reg [7:0] in_func_ff;
    reg [7:0] out_func_ff;
    reg [DW-1:0] on_delay_setting_ff;
    reg [DW-1:0] off_delay_setting_ff;
    reg reject_ff;
    reg [31:0] tick_cnt_ff;
    reg tick_ff;
    reg [DW-1:0] delay_cnt_ff;
    reg [DW-1:0] nxt_delay_cnt;
    reg nxt_out;
    reg [31:0] nxt_rd_dat;

    // Counter constants sized to the delay width
    localparam [DW-1:0] COUNT_ZERO = {DW{1'b0}};
    localparam [DW-1:0] COUNT_ONE = {{(DW-1){1'b0}}, 1'b1};

    wire access = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire wr = access & wb_we_in;
    wire timer_en = (in_func_ff == `FUNC_TIMER_IN) &&
                    (out_func_ff == `FUNC_TIMER_OUT);

    // Clamp a written delay to its legal range
    function [DW-1:0] clamp_delay;
        input [31:0] value;
        begin
            if (value[15:0] > {4'h0, `DELAY_MAX})
                clamp_delay = `DELAY_MAX;
            else
                clamp_delay = value[DW-1:0];
        end
    endfunction

    // Saturates, so a count can never wrap back and fire early
    function [DW-1:0] inc_count;
        input [DW-1:0] count;
        begin
            if (&count)
                inc_count = count;
            else
                inc_count = count + COUNT_ONE;
        end
    endfunction

    // Pending delay has run out; a zero setting passes at once
    function delay_done;
        input [DW-1:0] count;
        input [DW-1:0] setting;
        input tick;
        begin
            if (setting == COUNT_ZERO)
                delay_done = 1'b1;
            else
                delay_done = tick && (count >= setting);
        end
    endfunction

    // Delay writes during a run are dropped and flagged instead
    wire delay_adr = (wb_adr_in == `REG_ON_DELAY_ADDR) || (wb_adr_in == `REG_OFF_DELAY_ADDR);
    wire set_reject = wr && delay_adr && drive_running_in;
    wire clr_reject = wr && (wb_adr_in == `REG_STATUS_ADDR) && wb_sel_in[0] &&
                      wb_dat_in[`STAT_REJ_BIT];

    // Set wins over a clear in the same cycle
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n)
            reject_ff <= 1'b0;
        else if (set_reject)
            reject_ff <= 1'b1;
        else if (clr_reject)
            reject_ff <= 1'b0;
    end

    // Read word of the addressed register; unmapped offsets read zero
    always @* begin
        case (wb_adr_in)
            `REG_CTRL_ADDR:
                nxt_rd_dat = {15'h0000, drive_running_in, out_func_ff, in_func_ff};
            `REG_ON_DELAY_ADDR:
                nxt_rd_dat = {20'h0_0000, on_delay_setting_ff};
            `REG_OFF_DELAY_ADDR:
                nxt_rd_dat = {20'h0_0000, off_delay_setting_ff};
            `REG_STATUS_ADDR:
                nxt_rd_dat = {28'h000_0000, reject_ff, timer_en, timer_in, timer_out};
            default:
                nxt_rd_dat = 32'h0000_0000;
        endcase
    end

    // Register write path and registered read data
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            in_func_ff <= 8'h00;
            out_func_ff <= 8'h00;
            on_delay_setting_ff <= `DELAY_RESET;
            off_delay_setting_ff <= `DELAY_RESET;
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= access;
            if (wr) begin
                case (wb_adr_in)
                    `REG_CTRL_ADDR: begin
                        if (wb_sel_in[0])
                            in_func_ff <= wb_dat_in[7:0];
                        if (wb_sel_in[1])
                            out_func_ff <= wb_dat_in[15:8];
                    end
                    `REG_ON_DELAY_ADDR: begin
                        if (!drive_running_in && wb_sel_in[1:0] == 2'b11)
                            on_delay_setting_ff <= clamp_delay(wb_dat_in);
                    end
                    `REG_OFF_DELAY_ADDR: begin
                        if (!drive_running_in && wb_sel_in[1:0] == 2'b11)
                            off_delay_setting_ff <= clamp_delay(wb_dat_in);
                    end
                    default: begin
                    end
                endcase
            end
            if (access && !wb_we_in)
                wb_dat_out <= nxt_rd_dat;
            else
                wb_dat_out <= 32'h0000_0000;
        end
    end

    // 0.1 s tick; a free-running tick gives up to one tick of slack per delay
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= TICK_CYCLES - 1) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // Delay filter: count ticks while input differs from output
    always @* begin
        nxt_delay_cnt = delay_cnt_ff;
        nxt_out = timer_out;
        if (!timer_en) begin
            nxt_delay_cnt = {DW{1'b0}};
            nxt_out = 1'b0;
        end else if (timer_in == timer_out) begin
            nxt_delay_cnt = {DW{1'b0}};
        end else if (timer_in) begin
            if (delay_done(delay_cnt_ff, on_delay_setting_ff, tick_ff)) begin
                nxt_out = 1'b1;
                nxt_delay_cnt = COUNT_ZERO;
            end else if (tick_ff) begin
                nxt_delay_cnt = inc_count(delay_cnt_ff);
            end
        end else begin
            if (delay_done(delay_cnt_ff, off_delay_setting_ff, tick_ff)) begin
                nxt_out = 1'b0;
                nxt_delay_cnt = COUNT_ZERO;
            end else if (tick_ff) begin
                nxt_delay_cnt = inc_count(delay_cnt_ff);
            end
        end
    end

    // Output pin comes straight from this flop, no decode behind it
    always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            delay_cnt_ff <= {DW{1'b0}};
            timer_out <= 1'b0;
        end else begin
            delay_cnt_ff <= nxt_delay_cnt;
            timer_out <= nxt_out;
        end
    end

endmodule // delay_timer_io_filter

/* File: delay_timer_io_filter_sva.sv */
// Port checker for the delay timer block.
// Assumes one clock; the bench toggles the input both with the timer enabled and with it disabled.
`timescale 1ns/1ps
module delay_timer_io_filter_sva (
    input wire sys_clk_in,
    input wire nrst_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_ack_out,
    input wire [31:0] wb_dat_out,
    input wire timer_in,
    input wire timer_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    bus_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("access not acknowledged");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data outside ack");
    on_cause_a: assert property ($rose(timer_out) |-> $past(timer_in))
        else $error("output rose without input");
    // Every fall is excused, since the function codes are not visible to this checker
    change_cause_a: assert property ($changed(timer_out) |->
        $past(timer_in) != $past(timer_out) || !timer_out) else $error("output moved alone");
    cover property ($rose(timer_out));
    cover property ($fell(timer_out));
    cover property (wb_ack_out && wb_dat_out != 32'h0000_0000);
endmodule // delay_timer_io_filter_sva
bind delay_timer_io_filter delay_timer_io_filter_sva delay_timer_io_filter_sva_i (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .timer_in(timer_in), .timer_out(timer_out));

/* File: delay_timer_io_filter_tb.sv */
// Self-checking bench: Wishbone setup, bouncing contact on the timer input.
// Assumes a tick of 10 clocks, so 0.1 s of delay is 10 cycles here.
`timescale 1ns/1ps
module delay_timer_io_filter_tb;
    reg sys_clk_in = 0, nrst_in = 0, cyc = 0, we = 0, run = 0, cmd = 0;
    reg [7:0] adr = 8'h00;
    reg [3:0] bounce = 4'h8;
    reg [31:0] wdat = 32'h0000_0000, rd;
    wire [31:0] dat;
    wire ack, tin, tout;
    integer num_errors = 0, num_checks = 0, k;
    always #10 sys_clk_in = ~sys_clk_in;
    delay_timer_io_filter #(.TICK_CYCLES(10)) delay_timer_io_filter_i (.sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dat), .wb_ack_out(ack),
        .drive_running_in(run), .timer_in(tin), .timer_out(tout));
    contact_model contact_model_i (.clk_in(sys_clk_in), .cmd_in(cmd), .bounce_in(bounce),
        .contact_out(tin));
    task stop_test;
        begin
            $display("errors %0d checks %0d", num_errors, num_checks);
            if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_in);
            cyc <= 1;
            we <= w;
            adr <= a;
            wdat <= d;
            k = 0;
            do begin @(posedge sys_clk_in); k = k + 1; end while (ack !== 1'b1 && k < 20);
            rd = dat;
            cyc <= 0;
            if (k >= 20) begin num_errors = num_errors + 1; stop_test; end
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] e);
        begin wb(0, a, 32'h0000_0000); check(rd, e); end
    endtask
    task wait_out(input v, input integer lo, input integer hi);
        begin
            repeat (lo) @(posedge sys_clk_in);
            check(tout, !v);
            k = 0;
            while (tout !== v && k < hi) begin @(posedge sys_clk_in); k = k + 1; end
            check(tout, v);
        end
    endtask
    task t_wrong_code;
        begin
            wb(1, 8'h00, 32'h0000_0C11);
            cmd <= 1;
            repeat (60) @(posedge sys_clk_in);
            check(tout, 0);
            rd_chk(8'h0C, 32'h0000_0002);
            cmd <= 0;
            repeat (20) @(posedge sys_clk_in);
        end
    endtask
    task t_delays;
        begin
            wb(1, 8'h00, 32'h0000_0C12);
            wb(1, 8'h04, 32'h0000_0003);
            wb(1, 8'h08, 32'h0000_0002);
            cmd <= 1;
            wait_out(1, 33, 25);
            cmd <= 0;
            wait_out(0, 23, 25);
        end
    endtask
    task t_lock;
        begin
            run <= 1;
            wb(1, 8'h08, 32'h0000_0005);
            rd_chk(8'h08, 32'h0000_0002);
            rd_chk(8'h0C, 32'h0000_000C);
            rd_chk(8'h00, 32'h0001_0C12);
            run <= 0;
            wb(1, 8'h04, 32'h0000_0FFF);
            rd_chk(8'h04, 32'h0000_0BB8);
            rd_chk(8'h10, 32'h0000_0000);
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_in);
        nrst_in <= 1;
        repeat (3) @(posedge sys_clk_in);
        rd_chk(8'h04, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_0000);
        t_wrong_code;
        t_delays;
        t_lock;
        stop_test;
    end
endmodule // delay_timer_io_filter_tb
